//--- include/ttc_pkg.sv
// Purpose: Shared constants and types for the tape timer BCD down counter.
// Assumes: 20 MHz system clock; digit slots paced at 432 kHz.
// Notes: Summary list below names the behaviour the block keeps.
//
// Summary of operation
// R1: Eight BCD digits recirculate, one per slot.
// R2: Down mode keeps adder carry input zero.
// R3: No pulse or borrow: digits recirculate unchanged.
// R4: Boundary detector adds zero when counting down.
// R5: Least digit modulus follows tape speed.
// R6: Reload equals modulus plus fifteen, mod sixteen.
// R7: Pending tach sets carry at t0.
// R8: Result fifteen flags borrow, sets carry.
// R9: On borrow, reload value replaces adder result.
// R10: Later slots decrement when carry was set.
// R11: Carry output disabled during slot t7.
// R12: Abort low forces carry output low.
// R13: Transport asserts abort when tape runs out.
// R14: Direction sampled per slot edge; low counts down.
// R15: Clear low zeroes digits, blocks tach, carry.
// R16: Tach held pending until next t0 sample.
package ttc_pkg;
	// Clock and slot pacing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SLOT_HZ = 432_000;
	// Longest slot that fits the slot rate, rounded down
	localparam int unsigned SLOT_CYC = CLK_HZ / SLOT_HZ;
	// Digit geometry
	localparam int DIGITS = 8;
	localparam int DIGIT_W = 4;
	typedef logic [DIGIT_W-1:0] ttc_digit_t;
	typedef logic [2:0] ttc_slot_t;
	localparam ttc_slot_t FIRST_SLOT = 3'h0;
	localparam ttc_slot_t LAST_SLOT = 3'h7;
	localparam ttc_digit_t DIGIT_ZERO = 4'h0;
	// All ones: zero minus one, also add-fifteen operand
	localparam ttc_digit_t DIGIT_ALL1 = 4'hf;
	// Least digit modulus per speed select code
	localparam logic [1:0] SPD_30 = 2'h0;
	localparam logic [1:0] SPD_15 = 2'h1;
	localparam logic [1:0] SPD_7P5 = 2'h2;
	localparam ttc_digit_t MOD_30 = 4'h8;
	localparam ttc_digit_t MOD_15 = 4'h4;
	localparam ttc_digit_t MOD_7P5 = 4'h2;
	localparam ttc_digit_t MOD_3P75 = 4'h1;
	// Moduli of digits t7..t1, t1 in the low nibble
	localparam logic [27:0] MOD_UPPER = 28'ha6a6aaa;
	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_COUNT = 4'h8;
	localparam logic [31:0] CTRL_RST = 32'h0;
	localparam int CTRL_CLR_BIT = 0;
	localparam int STAT_DIR_BIT = 0;
	localparam int STAT_ABORT_BIT = 1;
	localparam int STAT_CLR_BIT = 2;
	localparam int STAT_PEND_BIT = 3;
	localparam int STAT_SLOT_LSB = 4;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- include/ttc_store_if.sv
// Purpose: Port bundle between the counter core and its digit store.
// Assumes: One write and one registered read per clock.
// Notes: Address is the digit slot.
`timescale 1ns/10ps
`default_nettype none
interface ttc_store_if;
	logic [2:0] addr; // Digit slot addressed
	logic wr_en; // Write back this cycle
	logic [3:0] wr_data; // Digit written back
	logic [3:0] rd_data; // Registered read of addr
	modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
	modport store (input addr, input wr_en, input wr_data, output rd_data);
endinterface
`default_nettype wire

//--- rtl/ttc_digit_alu.sv
// Purpose: Digit adder, boundary detector and reload path in down mode.
// Assumes: Digit operands are 4-bit, sums wrap modulo sixteen.
// Notes: Purely combinational.
`timescale 1ns/10ps
`default_nettype none
module ttc_digit_alu (
	input wire ttc_pkg::ttc_digit_t digit_i,
	input wire logic dec_i,
	input wire ttc_pkg::ttc_digit_t mod_i,
	output ttc_pkg::ttc_digit_t sum_o,
	output ttc_pkg::ttc_digit_t reload_o,
	output logic borrow_o
);
	import ttc_pkg::*;

	ttc_digit_t b_op; // Second adder operand
	ttc_digit_t bound; // Boundary detector output

	// R2: zero carry in
	assign b_op = dec_i ? DIGIT_ALL1 : DIGIT_ZERO;
	assign sum_o = digit_i + b_op;
	// R4: detector adds zero
	assign bound = sum_o + DIGIT_ZERO;
	// R8: fifteen flags borrow
	assign borrow_o = dec_i && (bound == DIGIT_ALL1);
	// R6: modulus plus fifteen
	assign reload_o = mod_i + DIGIT_ALL1;
endmodule
`default_nettype wire

//--- rtl/ttc_digit_store.sv
// Purpose: Eight-digit store that stands in for the recirculating register.
// Assumes: Read data one clock after the address.
// Notes: Zeroed by reset so the count starts defined.
`timescale 1ns/10ps
`default_nettype none
module ttc_digit_store #(
	parameter int DEPTH = 8
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	ttc_store_if.store st
);
	import ttc_pkg::*;

	ttc_digit_t mem_q [DEPTH]; // Digit storage
	ttc_digit_t rd_q; // Registered read port

	////////////////////////////////////////////////////////////////
	// Storage write
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				mem_q[i] <= DIGIT_ZERO;
			end
		end
		else if (st.wr_en)
		begin
			mem_q[st.addr] <= st.wr_data;
		end
	end

	// Registered read, so the core sees a flop output
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rd_q <= DIGIT_ZERO;
		else
			rd_q <= mem_q[st.addr];
	end

	assign st.rd_data = rd_q;
endmodule
`default_nettype wire

//--- rtl/ttc_tape_timer.sv
// Purpose: Eight-digit BCD tape timer counting tach pulses down.
// Assumes: Transport pins asynchronous; AXI4-Lite on mclk_i.
// Notes: In up direction the digits are held; up counting lives elsewhere.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ttc_tape_timer #(
	parameter int ADDR_W = 4
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic tach_i,
	input wire logic tape_direction_command_i,
	input wire logic counter_clear_n_i,
	input wire logic abort_n_i,
	input wire logic [1:0] speed_sel_i,
	output logic [31:0] count_o,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	import ttc_pkg::*;

	localparam logic [5:0] SLOT_END = 6'(SLOT_CYC - 1); // Last cycle of a slot

	// Pin synchronisers: tach, dir, clear, abort, speed[1:0]
	logic [5:0] pin_meta_q;
	logic [5:0] pin_sync_q;
	logic tach_s, dir_s, clear_n_s, abort_n_s;
	logic [1:0] speed_s;
	logic tach_prev_q; // For tach edge detection
	logic tach_edge;
	// Slot pacing
	logic [5:0] cyc_q;
	ttc_slot_t slot_q;
	logic tick; // Last cycle of the current slot
	// Counter state
	logic carry_q; // Carry flip-flop
	logic pend_q; // Tach pending for next t0
	logic dir_up_q; // Direction latch, high is up and holds the digits
	logic ctrl_clr_q; // Software clear
	logic [31:0] count_q; // Shadow of all digits
	// Datapath
	logic clr;
	logic carry_eff;
	ttc_digit_t mod_cur, sum, reload, wr_digit;
	logic borrow;
	// Bus slave state
	logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic do_wr;

	ttc_store_if st ();

	////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every transport pin
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_meta_q <= 6'h0;
			pin_sync_q <= 6'h0;
		end
		else
		begin
			pin_meta_q <= {speed_sel_i, abort_n_i, counter_clear_n_i,
				tape_direction_command_i, tach_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign tach_s = pin_sync_q[0];
	assign dir_s = pin_sync_q[1];
	assign clear_n_s = pin_sync_q[2];
	assign abort_n_s = pin_sync_q[3];
	assign speed_s = pin_sync_q[5:4];

	// Edge detector reads only the settled stage
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			tach_prev_q <= 1'b0;
		else
			tach_prev_q <= tach_s;
	end

	assign tach_edge = tach_s && !tach_prev_q;

	////////////////////////////////////////////////////////////////
	// Slot pacing at the slot rate
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cyc_q <= 6'h0;
		else if (tick)
			cyc_q <= 6'h0;
		else
			cyc_q <= cyc_q + 6'h1;
	end

	assign tick = (cyc_q == SLOT_END);

	// R1: one digit per slot
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			slot_q <= FIRST_SLOT;
		else if (tick)
			slot_q <= slot_q + 3'h1;
	end

	////////////////////////////////////////////////////////////////
	// Direction latch
	// R14: sampled on slot edge
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			dir_up_q <= 1'b0;
		else if (tick)
			dir_up_q <= dir_s;
	end

	// R15: clear from pin or software
	assign clr = !clear_n_s || ctrl_clr_q;

	// R16: capture tach until t0
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pend_q <= 1'b0;
		else if (clr)
			pend_q <= 1'b0;
		else if (tach_edge)
			pend_q <= 1'b1; // Set wins over the t0 consume
		else if (tick && slot_q == LAST_SLOT)
			pend_q <= 1'b0;
	end

	// Carry flip-flop, updated at each slot boundary
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			carry_q <= 1'b0;
		else if (tick)
		begin
			if (clr)
				carry_q <= 1'b0;
			// R7: pending tach arms t0
			else if (slot_q == LAST_SLOT)
				carry_q <= pend_q;
			// R8: borrow arms next digit
			else
				carry_q <= borrow;
		end
	end

	// R11: gated off in t7
	// R12: abort forces low
	assign carry_eff = carry_q && (slot_q != LAST_SLOT) && abort_n_s
		&& !clr && !dir_up_q;

	////////////////////////////////////////////////////////////////
	// Modulus for the digit in the current slot
	// R5: speed picks least modulus
	always_comb
	begin
		mod_cur = MOD_UPPER[{slot_q - 3'h1, 2'b00} +: 4];
		if (slot_q == FIRST_SLOT)
		begin
			case (speed_s)
				SPD_30: mod_cur = MOD_30;
				SPD_15: mod_cur = MOD_15;
				SPD_7P5: mod_cur = MOD_7P5;
				default: mod_cur = MOD_3P75;
			endcase
		end
	end

	// R10: decrement when carry set
	ttc_digit_alu u_alu (
		.digit_i(st.rd_data),
		.dec_i(carry_eff),
		.mod_i(mod_cur),
		.sum_o(sum),
		.reload_o(reload),
		.borrow_o(borrow)
	);

	// Write-back selection
	always_comb
	begin
		if (clr)
			wr_digit = DIGIT_ZERO;
		// R9: reload replaces sum
		else if (borrow)
			wr_digit = reload;
		// R3: unchanged without decrement
		else
			wr_digit = sum;
	end

	assign st.addr = slot_q;
	assign st.wr_en = tick;
	assign st.wr_data = wr_digit;

	ttc_digit_store #(
		.DEPTH(DIGITS)
	) u_store (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.st(st)
	);

	// Shadow copy so software sees all digits at once
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			count_q <= 32'h0;
		else if (tick)
			count_q[{slot_q, 2'b00} +: 4] <= wr_digit;
	end

	assign count_o = count_q;

	////////////////////////////////////////////////////////////////
	// AXI4-Lite write channels, taken in either order
	assign s_axi_awready_o = !aw_full_q && !bvalid_q;
	assign s_axi_wready_o = !w_full_q && !bvalid_q;
	assign do_wr = aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			aw_full_q <= 1'b0;
			awaddr_q <= '0;
		end
		else if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			aw_full_q <= 1'b1;
			awaddr_q <= s_axi_awaddr_i;
		end
		else if (do_wr)
			aw_full_q <= 1'b0;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			w_full_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end
		else if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			w_full_q <= 1'b1;
			wdata_q <= s_axi_wdata_i;
			wstrb_q <= s_axi_wstrb_i;
		end
		else if (do_wr)
			w_full_q <= 1'b0;
	end

	// Write response; only the control word is writable
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= (awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready_i)
			bvalid_q <= 1'b0;
	end

	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;

	// Control register, low byte lane only
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ctrl_clr_q <= CTRL_RST[CTRL_CLR_BIT];
		else if (do_wr && awaddr_q == REG_CTRL && wstrb_q[0])
			ctrl_clr_q <= wdata_q[CTRL_CLR_BIT];
	end

	// Read channel: one-cycle registered answer
	assign s_axi_arready_o = !rvalid_q;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0;
			case (s_axi_araddr_i)
				REG_CTRL: rdata_q[CTRL_CLR_BIT] <= ctrl_clr_q;
				REG_STAT:
				begin
					rdata_q[STAT_DIR_BIT] <= dir_up_q;
					rdata_q[STAT_ABORT_BIT] <= !abort_n_s;
					rdata_q[STAT_CLR_BIT] <= clr;
					rdata_q[STAT_PEND_BIT] <= pend_q;
					rdata_q[STAT_SLOT_LSB +: 3] <= slot_q;
				end
				REG_COUNT: rdata_q <= count_q;
				default: rresp_q <= RESP_SLVERR;
			endcase
		end
		else if (s_axi_rready_i)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	////////////////////////////////////////////////////////////////
	// Checks on the counting path
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_slot_adv;
		tick |=> slot_q == ttc_slot_t'($past(slot_q) + 3'h1);
	endproperty
	a_slot_adv: assert property (p_slot_adv) // R1
		else $error("slot did not advance on tick");

	property p_dec_op;
		!dir_up_q && !clr && !borrow |-> sum == ttc_digit_t'(st.rd_data
			- {3'h0, carry_eff});
	endproperty
	a_dec_op: assert property (p_dec_op) // R2
		else $error("down-mode sum is not digit minus carry");

	property p_hold;
		tick && !carry_eff && !clr |-> st.wr_data == st.rd_data;
	endproperty
	a_hold: assert property (p_hold) // R3
		else $error("digit changed without decrement");

	property p_mod0;
		slot_q == FIRST_SLOT && speed_s == SPD_30 |-> mod_cur == MOD_30;
	endproperty
	a_mod0: assert property (p_mod0) // R5
		else $error("wrong least digit modulus");

	property p_reload;
		reload == ttc_digit_t'(mod_cur - 4'h1);
	endproperty
	a_reload: assert property (p_reload) // R6
		else $error("reload is not modulus minus one");

	property p_arm_t0;
		tick && slot_q == LAST_SLOT && pend_q && !clr
			|=> carry_q && slot_q == FIRST_SLOT;
	endproperty
	a_arm_t0: assert property (p_arm_t0) // R7
		else $error("pending tach did not arm t0");

	property p_ripple;
		tick && borrow && !clr |=> carry_q;
	endproperty
	a_ripple: assert property (p_ripple) // R8
		else $error("borrow did not arm carry for next slot");

	// Carry may only move at a slot boundary, so it covers the whole next digit
	property p_carry_hold;
		!tick |=> $stable(carry_q);
	endproperty
	a_carry_hold: assert property (p_carry_hold) // R10
		else $error("carry changed inside a slot");

	property p_reload_sel;
		tick && borrow && !clr |-> st.wr_data == ttc_digit_t'(mod_cur - 4'h1);
	endproperty
	a_reload_sel: assert property (p_reload_sel) // R9
		else $error("borrow did not load reload value");

	property p_t7_off;
		slot_q == LAST_SLOT |-> !carry_eff && !borrow;
	endproperty
	a_t7_off: assert property (p_t7_off) // R11
		else $error("carry active in last slot");

	property p_abort;
		!abort_n_s |-> !carry_eff;
	endproperty
	a_abort: assert property (p_abort) // R12
		else $error("carry active during abort");

	property p_dir;
		tick |=> dir_up_q == $past(dir_s);
	endproperty
	a_dir: assert property (p_dir) // R14
		else $error("direction latch missed sample");

	property p_clear;
		tick && clr |-> st.wr_data == DIGIT_ZERO ##1 !pend_q && !carry_q;
	endproperty
	a_clear: assert property (p_clear) // R15
		else $error("clear did not zero digit and carry");

	property p_pend;
		tach_edge && !clr |=> pend_q;
	endproperty
	a_pend: assert property (p_pend) // R16
		else $error("tach edge not held pending");

	cover property (tick && borrow && slot_q == FIRST_SLOT);
	cover property (tick && borrow && slot_q == 3'h1);
	cover property (pend_q && !abort_n_s && carry_q);
endmodule
`default_nettype wire

//--- tb/ttc_tape_timer_tb.sv
// Purpose: Self-checking bench for the tape timer down counter and its registers.
// Assumes: Slot of 46 clocks, so one full digit cycle is 368 clocks.
// Notes: Count waits are fixed spans that cover a cycle wait plus a full ripple.
`timescale 1ns/10ps
`default_nettype none
module ttc_tape_timer_tb;
	import ttc_pkg::*;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic clr_n = 1'b1; // Clear pin, pushbutton side
	logic tach, dir, abort_n;
	logic [1:0] spd;
	logic [31:0] count;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf; // Write strobes, all lanes unless a test masks one
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rd, exp_c;
	int errors = 0;
	int checks = 0;
	////////////////////////////////////////////////////////////////////////////
	// Clock at 20 MHz
	initial
	begin
		forever #25 mclk_i = ~mclk_i;
	end
	ttc_transport_model u_tr (.mclk_i(mclk_i), .tach_o(tach), .dir_o(dir),
		.abort_n_o(abort_n), .speed_o(spd));
	ttc_tape_timer dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .tach_i(tach),
		.tape_direction_command_i(dir), .counter_clear_n_i(clr_n), .abort_n_i(abort_n),
		.speed_sel_i(spd), .count_o(count), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));
	////////////////////////////////////////////////////////////////////////////
	// Compare and count; a mismatch is reported at once
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Write one word; handshake flags sampled at the falling edge, so the value
	// seen is the one the next rising edge takes, without a race on that edge
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		int n;
		b_t = 1'b0;
		n = 0;
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_t && n < 100)
		begin
			@(negedge mclk_i);
			aw_t = awvalid & (awready === 1'b1);
			w_t = wvalid & (wready === 1'b1);
			b_t = (bvalid === 1'b1);
			resp = bresp;
			@(posedge mclk_i);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) bready <= 1'b0;
			n++;
		end
		if (!b_t) chk("write response", 32'h0, 32'h1);
	endtask
	// Read one word, same sampling scheme as the write
	task automatic axi_read(input logic [3:0] a);
		logic ar_t, r_t;
		int n;
		r_t = 1'b0;
		n = 0;
		@(posedge mclk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_t && n < 100)
		begin
			@(negedge mclk_i);
			ar_t = arvalid & (arready === 1'b1);
			r_t = (rvalid === 1'b1);
			rd = rdata;
			resp = rresp;
			@(posedge mclk_i);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) rready <= 1'b0;
			n++;
		end
		if (!r_t) chk("read response", 32'h0, 32'h1);
	endtask
	// Expected count after one decrement: borrow ripples, top digit never touched
	function automatic logic [31:0] dec_exp(input logic [31:0] c, input logic [1:0] s);
		logic [3:0] m, dg;
		logic br;
		br = 1'b1;
		for (int k = 0; k < 7; k++)
		begin
			m = (k == 0) ? (4'h8 >> s) : MOD_UPPER[4*k-4 +: 4];
			if (br)
			begin
				dg = c[4*k +: 4] - 4'h1;
				br = (dg == 4'hf);
				c[4*k +: 4] = br ? m - 4'h1 : dg;
			end
		end
		return c;
	endfunction
	// Pulse and give it a cycle wait plus a full ripple to land
	task automatic pulse_wait();
		u_tr.tach_pulse();
		repeat (800) @(posedge mclk_i);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Verdict, reached from the main sequence or the watchdog
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog well beyond the roughly 17k clocks the tests take
	initial
	begin
		#(60000 * 50);
		errors++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (5) @(posedge mclk_i);
		resetn_i <= 1'b1;
		chk("count after reset", count, 32'h0);
		axi_read(REG_CTRL);
		chk("ctrl reset", rd, CTRL_RST);
		axi_read(4'hc);
		chk("unmapped read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		axi_write(REG_COUNT, 32'h1234);
		chk("count write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
		// Every speed: clear, then three decrements from zero
		for (int s = 0; s < 4; s++)
		begin
			u_tr.set_mode(1'b0, s[1:0]);
			@(posedge mclk_i);
			clr_n <= 1'b0;
			repeat (420) @(posedge mclk_i);
			clr_n <= 1'b1;
			chk("count cleared by pin", count, 32'h0);
			exp_c = 32'h0;
			for (int p = 0; p < 3; p++)
			begin
				pulse_wait();
				exp_c = dec_exp(exp_c, s[1:0]);
				chk("count after tach", count, exp_c);
			end
		end
		// No pulse: digits recirculate unchanged
		repeat (800) @(posedge mclk_i);
		chk("idle count", count, exp_c);
		axi_read(REG_COUNT);
		chk("count register", rd, exp_c);
		// Abort low: pulses not counted
		u_tr.run_out(1'b1);
		repeat (10) @(posedge mclk_i);
		pulse_wait();
		chk("count under abort", count, exp_c);
		axi_read(REG_STAT);
		chk("abort status", {31'h0, rd[STAT_ABORT_BIT]}, 32'h1);
		u_tr.run_out(1'b0);
		repeat (800) @(posedge mclk_i);
		// Forward direction latched, digits held
		// Direction latch moves only at a slot boundary: wait past one slot
		u_tr.set_mode(1'b1, 2'h0);
		repeat (60) @(posedge mclk_i);
		axi_read(REG_STAT);
		chk("direction up", {31'h0, rd[STAT_DIR_BIT]}, 32'h1);
		pulse_wait();
		chk("count when up", count, exp_c);
		u_tr.set_mode(1'b0, 2'h0);
		repeat (60) @(posedge mclk_i);
		axi_read(REG_STAT);
		chk("direction down", {31'h0, rd[STAT_DIR_BIT]}, 32'h0);
		pulse_wait();
		chk("count back in down", count, dec_exp(exp_c, 2'h0));
		// Low byte lane masked: control word must not change
		wstrb <= 4'he;
		axi_write(REG_CTRL, 32'h1);
		axi_read(REG_CTRL);
		chk("ctrl masked by strobe", rd, CTRL_RST);
		wstrb <= 4'hf;
		// Software clear through the control register
		axi_write(REG_CTRL, 32'h1);
		chk("ctrl write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
		repeat (420) @(posedge mclk_i);
		chk("count after soft clear", count, 32'h0);
		axi_read(REG_STAT);
		chk("clear status", {31'h0, rd[STAT_CLR_BIT]}, 32'h1);
		pulse_wait();
		chk("tach blocked by clear", count, 32'h0);
		axi_write(REG_CTRL, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire

//--- tb/ttc_transport_model.sv
// Purpose: Behavioural tape transport driving tach, direction, speed and abort pins.
// Assumes: The bench commands it by task call; pins change just after rising edges.
// Notes: Tach pulses are wide enough for the two-flop pin synchroniser.
`timescale 1ns/10ps
`default_nettype none
module ttc_transport_model (
	input wire logic mclk_i,
	output logic tach_o,
	output logic dir_o,
	output logic abort_n_o,
	output logic [1:0] speed_o
);
	// Idle transport: no pulse, reverse direction, tape present, top speed
	initial
	begin
		tach_o = 1'b0;
		dir_o = 1'b0;
		abort_n_o = 1'b1;
		speed_o = 2'h0;
	end
	// One tach pulse, four clocks high then four low, so a slow sync still sees it
	task automatic tach_pulse();
		@(posedge mclk_i);
		tach_o <= 1'b1;
		repeat (4) @(posedge mclk_i);
		tach_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask
	task automatic run_out(input logic out);
		@(posedge mclk_i);
		abort_n_o <= ~out;
	endtask
	// Direction level (high is forward) and speed select code
	task automatic set_mode(input logic up, input logic [1:0] spd);
		@(posedge mclk_i);
		dir_o <= up;
		speed_o <= spd;
	endtask
endmodule
`default_nettype wire
